// ---- ctlc_top.sv ----
// Calibration trigger selection, status pin routing, low-power sleep and
// wake sequencing and core gain trim. Assumes the calibration engine
// supplies its flags as levels synchronous to core_clk.
`timescale 1ns/1ps
// Overview of operation
// - Status select routes flag or low
// - Select 0 uses software bit only
// - Select 1 uses hardware pin only
// - Software bit mimics pin, resets high
// - Sleep code only with lowpower, autonomous
// - Sleep codes map to fixed periods
// - Settle code sets wake-to-calibration delay
// - Trigger sleep: high sleeps, low wakes
// - Lowpower needs background calibration enabled
// - Gain adjust trims all cores
// - Gain adjust loads fuse value at reset
// - Foreground flag high once done/skipped
// - Stopped flag follows halt and resume
module ctlc_top
  import ctlc_pkg::*;
#(
  parameter logic [ctlc_pkg::DELAY_W-1:0] SLEEP_CYCLES [8] =
    ctlc_pkg::SLEEP_CYC,
  parameter logic [ctlc_pkg::DELAY_W-1:0] WAKE_CYCLES [4] =
    ctlc_pkg::WAKE_CYC
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Pins
  input wire logic hardware_trigger_pin,
  output logic calibration_status_pin,
  // Calibration engine
  input wire logic background_cal_enable,
  input wire logic foreground_complete_flag,
  input wire logic cal_stopped_flag,
  input wire logic cal_alarm_flag,
  input wire logic cal_pass_done,
  output logic calibration_trigger,
  output logic offline_core_sleep,
  output logic offline_cal_start,
  // Trim
  input wire logic [7:0] fuse_gain_adjust,
  output logic [7:0] core_gain_adjust_out,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [7:0] pin_config_reg;
  logic [7:0] soft_trig_reg;
  logic [7:0] lowpower_reg;
  logic [7:0] gain_adjust_reg;
  logic [IRQ_BITS-1:0] irq_status_reg;
  logic [IRQ_BITS-1:0] irq_mask_reg;
  logic [IRQ_BITS-1:0] irq_event;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic trig_meta_reg;
  logic trig_sync_reg;
  logic trig_sel;
  logic stat_pin_reg;
  logic stat_pin_next;
  logic fg_prev_reg;
  logic stop_prev_reg;
  logic alarm_prev_reg;
  ctlc_state_t state_reg;
  ctlc_state_t state_next;
  logic lp_active;
  logic trigger_controlled_sleep_mode;
  logic [2:0] sleep_code;
  logic [1:0] wake_code;
  logic tmr_load;
  logic [DELAY_W-1:0] tmr_value;
  logic tmr_busy;
  logic tmr_done;
  logic sleep_reg;
  logic start_reg;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      pin_config_reg <= RST_PIN_CONFIG;
      soft_trig_reg <= RST_SOFT_TRIG;
      lowpower_reg <= RST_LOWPOWER;
      irq_mask_reg <= IRQ_BITS'(RST_IRQ);
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        OFS_PIN_CONFIG: pin_config_reg <= reg_wdata;
        OFS_SOFT_TRIG: soft_trig_reg <= reg_wdata;
        OFS_LOWPOWER: lowpower_reg <= reg_wdata;
        OFS_IRQ_MASK: irq_mask_reg <= reg_wdata[IRQ_BITS-1:0];
        default: ;
      endcase
    end
  end

  // Gain adjust takes the factory trim while reset is held
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      gain_adjust_reg <= fuse_gain_adjust;
    end
    else if (reg_wr && reg_addr == OFS_GAIN_ADJ)
    begin
      gain_adjust_reg <= reg_wdata;
    end
  end

  assign core_gain_adjust_out = gain_adjust_reg;

  // ----------------------------------------------------------------------
  // Register reads, data in the cycle after the strobe
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdata_next = 8'h00;
    case (reg_addr)
      OFS_PIN_CONFIG: rdata_next = pin_config_reg;
      OFS_SOFT_TRIG: rdata_next = soft_trig_reg;
      OFS_LOWPOWER: rdata_next = lowpower_reg;
      OFS_GAIN_ADJ: rdata_next = gain_adjust_reg;
      OFS_IRQ_STATUS: rdata_next = 8'(irq_status_reg);
      OFS_IRQ_MASK: rdata_next = 8'(irq_mask_reg);
      OFS_CAL_STATE:
      begin
        rdata_next = {1'b0, trig_sel, state_reg, cal_alarm_flag,
          sleep_reg, cal_stopped_flag, foreground_complete_flag};
      end
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      rdata_reg <= 8'h00;
    end
    else if (reg_rd)
    begin
      rdata_reg <= rdata_next;
    end
    else
    begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------------
  // Trigger synchroniser and source select
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      trig_meta_reg <= 1'b0;
      trig_sync_reg <= 1'b0;
    end
    else
    begin
      trig_meta_reg <= hardware_trigger_pin;
      trig_sync_reg <= trig_meta_reg;
    end
  end

  assign trig_sel = pin_config_reg[POS_TRIG_SEL] ?
    trig_sync_reg : soft_trig_reg[POS_SOFT_TRIG];
  assign calibration_trigger = trig_sel;

  // ----------------------------------------------------------------------
  // Status pin
  // ----------------------------------------------------------------------
  always_comb
  begin
    case (pin_config_reg[POS_STAT_SEL +: 2])
      STAT_FOREGROUND_COMPLETE_FLAG: stat_pin_next = foreground_complete_flag;
      STAT_STOPPED: stat_pin_next = cal_stopped_flag;
      STAT_ALARM: stat_pin_next = cal_alarm_flag;
      default: stat_pin_next = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      stat_pin_reg <= 1'b0;
    end
    else
    begin
      stat_pin_reg <= stat_pin_next;
    end
  end

  assign calibration_status_pin = stat_pin_reg;

  // ----------------------------------------------------------------------
  // Low-power sequencer
  // ----------------------------------------------------------------------
  assign lp_active = lowpower_reg[POS_LOWPOWER_CAL_ENABLE] & background_cal_enable;
  assign trigger_controlled_sleep_mode = lowpower_reg[POS_TRIGGER_CONTROLLED_SLEEP];
  assign sleep_code = lowpower_reg[POS_SLEEP_CODE +: 3];
  assign wake_code = lowpower_reg[POS_WAKE_CODE +: 2];

  always_comb
  begin
    state_next = state_reg;
    tmr_load = 1'b0;
    tmr_value = SLEEP_CYCLES[sleep_code];
    case (state_reg)
      CTLC_IDLE:
      begin
        if (lp_active)
        begin
          state_next = CTLC_SLEEP;
          tmr_load = !trigger_controlled_sleep_mode;
        end
      end
      CTLC_SLEEP:
      begin
        if (trigger_controlled_sleep_mode ? !trig_sel : tmr_done)
        begin
          state_next = CTLC_SETTLE;
          tmr_load = 1'b1;
          tmr_value = WAKE_CYCLES[wake_code];
        end
        else if (!trigger_controlled_sleep_mode && !tmr_busy)
        begin
          tmr_load = 1'b1;
        end
      end
      CTLC_SETTLE:
      begin
        if (tmr_done)
        begin
          state_next = CTLC_CALIB;
        end
      end
      CTLC_CALIB:
      begin
        if (cal_pass_done)
        begin
          state_next = CTLC_SLEEP;
          tmr_load = !trigger_controlled_sleep_mode;
        end
      end
      default: state_next = CTLC_IDLE;
    endcase
    if (!lp_active)
    begin
      state_next = CTLC_IDLE;
      tmr_load = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      state_reg <= CTLC_IDLE;
      sleep_reg <= 1'b0;
      start_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      sleep_reg <= (state_next == CTLC_SLEEP);
      start_reg <= (state_reg == CTLC_SETTLE) &&
        (state_next == CTLC_CALIB);
    end
  end

  assign offline_core_sleep = sleep_reg;
  assign offline_cal_start = start_reg;

  ctlc_interval_timer #(
    .WIDTH(DELAY_W)
  ) u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load(tmr_load),
    .abort(!lp_active),
    .load_value(tmr_value),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------------
  // Interrupts: rising flags and calibration starts, set beats clear
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      fg_prev_reg <= 1'b0;
      stop_prev_reg <= 1'b0;
      alarm_prev_reg <= 1'b0;
    end
    else
    begin
      fg_prev_reg <= foreground_complete_flag;
      stop_prev_reg <= cal_stopped_flag;
      alarm_prev_reg <= cal_alarm_flag;
    end
  end

  assign irq_event[IRQ_FOREGROUND_COMPLETE_FLAG] = foreground_complete_flag & ~fg_prev_reg;
  assign irq_event[IRQ_STOPPED] = cal_stopped_flag & ~stop_prev_reg;
  assign irq_event[IRQ_ALARM] = cal_alarm_flag & ~alarm_prev_reg;
  assign irq_event[IRQ_CAL_START] = start_reg;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      irq_status_reg <= IRQ_BITS'(RST_IRQ);
    end
    else
    begin
      irq_status_reg <= (irq_status_reg &
        ~((reg_wr && reg_addr == OFS_IRQ_STATUS) ?
        reg_wdata[IRQ_BITS-1:0] : '0)) | irq_event;
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_settle_entry;
    state_reg == CTLC_SLEEP && state_next == CTLC_SETTLE;
  endsequence

  a_status_pin_route: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    ##1 calibration_status_pin == $past(stat_pin_next))
    else $error("status pin does not follow select");

  a_status_forced_low: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    pin_config_reg[POS_STAT_SEL +: 2] == 2'h3 |=> !calibration_status_pin)
    else $error("status pin not low for select three");

  a_soft_source: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !pin_config_reg[POS_TRIG_SEL] |->
    calibration_trigger == soft_trig_reg[POS_SOFT_TRIG])
    else $error("software trigger not selected");

  a_hard_source: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    pin_config_reg[POS_TRIG_SEL] |->
    calibration_trigger == $past(hardware_trigger_pin, 2))
    else $error("hardware trigger not selected");

  a_soft_reset_high: assert property (
    @(posedge core_clk)
    $rose(rst_b) |-> soft_trig_reg == RST_SOFT_TRIG)
    else $error("software trigger not high after reset");

  a_lp_gate_off: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    !lp_active |=> state_reg == CTLC_IDLE && !offline_core_sleep)
    else $error("sequencer ran with lowpower off");

  a_trig_wake: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    lp_active && trigger_controlled_sleep_mode && state_reg == CTLC_SLEEP && !trig_sel
    |-> ##1 state_reg == CTLC_SETTLE)
    else $error("trigger low did not wake core");

  a_settle_start: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    s_settle_entry |=> tmr_busy)
    else $error("settle timer not started");

  a_sleep_hold: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    state_reg == CTLC_SLEEP && !trigger_controlled_sleep_mode && !tmr_done && lp_active
    |-> ##1 state_reg == CTLC_SLEEP)
    else $error("autonomous sleep ended early");

  a_gain_fuse: assert property (
    @(posedge core_clk)
    $rose(rst_b) |-> gain_adjust_reg == $past(fuse_gain_adjust))
    else $error("gain adjust not loaded from fuse");

  a_sync_two_flop: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    ##2 trig_sync_reg == $past(hardware_trigger_pin, 2))
    else $error("trigger synchroniser depth wrong");

endmodule

// ---- ctlc_pkg.sv ----
// Shared constants for the calibration trigger and low-power controller.
// Assumes a byte-wide register port and a converter clock equal to core_clk.
package ctlc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_PIN_CONFIG = 8'h6b;
  localparam logic [7:0] OFS_SOFT_TRIG = 8'h6c;
  localparam logic [7:0] OFS_LOWPOWER = 8'h6e;
  localparam logic [7:0] OFS_GAIN_ADJ = 8'h7a;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h74;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h75;
  localparam logic [7:0] OFS_CAL_STATE = 8'h76;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int POS_TRIG_SEL = 0;
  localparam int POS_STAT_SEL = 1;
  localparam int POS_SOFT_TRIG = 0;
  localparam int POS_LOWPOWER_CAL_ENABLE = 0;
  localparam int POS_TRIGGER_CONTROLLED_SLEEP = 1;
  localparam int POS_WAKE_CODE = 3;
  localparam int POS_SLEEP_CODE = 5;
  localparam logic [7:0] RST_PIN_CONFIG = 8'h00;
  localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
  localparam logic [7:0] RST_LOWPOWER = 8'h88;
  localparam logic [7:0] RST_IRQ = 8'h00;

  // ----------------------------------------------------------------------
  // Status pin select codes and interrupt bits
  // ----------------------------------------------------------------------
  localparam logic [1:0] STAT_FOREGROUND_COMPLETE_FLAG = 2'h0;
  localparam logic [1:0] STAT_STOPPED = 2'h1;
  localparam logic [1:0] STAT_ALARM = 2'h2;
  localparam int IRQ_FOREGROUND_COMPLETE_FLAG = 0;
  localparam int IRQ_STOPPED = 1;
  localparam int IRQ_ALARM = 2;
  localparam int IRQ_CAL_START = 3;
  localparam int IRQ_BITS = 4;

  // ----------------------------------------------------------------------
  // Timing, in converter clock periods, and the derived core cycles
  // ----------------------------------------------------------------------
  localparam int DELAY_W = 41;
  localparam longint CONV_PERIOD_PS = 64'd10000;
  localparam longint CORE_PERIOD_PS = 64'd10000;
  localparam longint SLEEP_PER [8] = '{
    64'd1152, 64'd4194432, 64'd33554560, 64'd268435584,
    64'd2147483776, 64'd17179869312, 64'd137438953600,
    64'd1099511627904};
  localparam longint WAKE_PER [4] = '{
    64'd1152, 64'd33554560, 64'd268435584, 64'd2147483776};
  localparam logic [DELAY_W-1:0] SLEEP_CYC [8] = '{
    DELAY_W'(SLEEP_PER[0] * CONV_PERIOD_PS / CORE_PERIOD_PS),
    DELAY_W'(SLEEP_PER[1] * CONV_PERIOD_PS / CORE_PERIOD_PS),
    DELAY_W'(SLEEP_PER[2] * CONV_PERIOD_PS / CORE_PERIOD_PS),
    DELAY_W'(SLEEP_PER[3] * CONV_PERIOD_PS / CORE_PERIOD_PS),
    DELAY_W'(SLEEP_PER[4] * CONV_PERIOD_PS / CORE_PERIOD_PS),
    DELAY_W'(SLEEP_PER[5] * CONV_PERIOD_PS / CORE_PERIOD_PS),
    DELAY_W'(SLEEP_PER[6] * CONV_PERIOD_PS / CORE_PERIOD_PS),
    DELAY_W'(SLEEP_PER[7] * CONV_PERIOD_PS / CORE_PERIOD_PS)};
  localparam logic [DELAY_W-1:0] WAKE_CYC [4] = '{
    DELAY_W'(WAKE_PER[0] * CONV_PERIOD_PS / CORE_PERIOD_PS),
    DELAY_W'(WAKE_PER[1] * CONV_PERIOD_PS / CORE_PERIOD_PS),
    DELAY_W'(WAKE_PER[2] * CONV_PERIOD_PS / CORE_PERIOD_PS),
    DELAY_W'(WAKE_PER[3] * CONV_PERIOD_PS / CORE_PERIOD_PS)};

  // ----------------------------------------------------------------------
  // Low-power sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CTLC_IDLE,
    CTLC_SLEEP,
    CTLC_SETTLE,
    CTLC_CALIB
  } ctlc_state_t;

endpackage

// ---- ctlc_interval_timer.sv ----
// Down-counting interval timer for the sleep and settle phases.
// Assumes load is a one-cycle pulse; done pulses load_value cycles later.
`timescale 1ns/1ps
module ctlc_interval_timer
#(
  parameter int WIDTH = 41
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Control
  input wire logic load,
  input wire logic abort,
  input wire logic [WIDTH-1:0] load_value,
  // Status
  output logic busy,
  output logic done
);

  generate
    if (WIDTH < 2)
    begin : g_bad_width
      $error("ctlc_interval_timer: WIDTH must be at least 2");
    end
  endgenerate

  logic [WIDTH-1:0] count_reg;
  logic busy_reg;
  logic done_reg;

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rst_b || abort)
    begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else if (load)
    begin
      // A zero load still waits one cycle
      count_reg <= (load_value == '0) ? '0 : load_value - 1'b1;
      busy_reg <= 1'b1;
      done_reg <= 1'b0;
    end
    else if (busy_reg && count_reg == '0)
    begin
      busy_reg <= 1'b0;
      done_reg <= 1'b1;
    end
    else
    begin
      if (busy_reg)
      begin
        count_reg <= count_reg - 1'b1;
      end
      done_reg <= 1'b0;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;

endmodule

// ---- ctlc_trig_src.sv ----
// Model of the external trigger driver and of the status pin monitor.
// Assumes the bench sets the wanted trigger level and the lag behind it.
`timescale 1ns/1ps
module ctlc_trig_src
(
  // Clock
  core_clk,
  // Control from the bench
  level_req,
  lag_ns,
  // Pins
  hardware_trigger_pin,
  calibration_status_pin,
  // Monitor result
  status_rises
);
  input wire logic core_clk;
  input wire logic level_req;
  input wire logic [7:0] lag_ns;
  output logic hardware_trigger_pin;
  input wire logic calibration_status_pin;
  output int status_rises;
  logic last_stat;

  initial
  begin
    hardware_trigger_pin = 1'b0;
    last_stat = 1'b0;
  end

  // Pin moves off the clock edge, as an unrelated source would
  always @(level_req)
  begin
    #(lag_ns);
    hardware_trigger_pin = level_req;
  end

  // Count rising edges seen on the status pin
  always @(posedge core_clk)
  begin
    if (calibration_status_pin === 1'b1 && last_stat === 1'b0)
      status_rises <= status_rises + 1;
    last_stat <= calibration_status_pin;
  end

  initial status_rises = 0;
endmodule

// ---- tb_ctlc_top.sv ----
// Self-checking bench for the calibration trigger and low-power control.
// Assumes short sleep and settle counts given through the top parameters.
`timescale 1ns/1ps
module tb_ctlc_top;
  import ctlc_pkg::*;
  localparam logic [DELAY_W-1:0] SLP [8] = '{41'd40, 41'd44, 41'd48,
    41'd52, 41'd56, 41'd60, 41'd64, 41'd68};
  localparam logic [DELAY_W-1:0] WAK [4] = '{41'd20, 41'd30, 41'd40,
    41'd50};
  logic core_clk, rst_b, reg_wr, reg_rd, trig_req, bce;
  logic fg, stp, alm, pass, irq, stat_pin, trig, slp, start, hw_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, fuse, gain, d, lag;
  logic [7:0] model [256];
  bit mapped [256];
  int fail_count, comparisons, seed, n, k, rises;

  // ----------------------------------------------------------------------
  // Design and partner
  // ----------------------------------------------------------------------
  ctlc_top #(.SLEEP_CYCLES(SLP), .WAKE_CYCLES(WAK)) dut (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .hardware_trigger_pin(hw_pin),
    .calibration_status_pin(stat_pin), .background_cal_enable(bce),
    .foreground_complete_flag(fg), .cal_stopped_flag(stp),
    .cal_alarm_flag(alm), .cal_pass_done(pass),
    .calibration_trigger(trig), .offline_core_sleep(slp),
    .offline_cal_start(start), .fuse_gain_adjust(fuse),
    .core_gain_adjust_out(gain), .irq(irq));
  ctlc_trig_src src (.core_clk(core_clk), .level_req(trig_req),
    .lag_ns(lag), .hardware_trigger_pin(hw_pin),
    .calibration_status_pin(stat_pin), .status_rises(rises));

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------------
  // Compare and bus tasks
  // ----------------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_span(input int got, input int exp, input int tol);
    comparisons++;
    if (got < exp - tol || got > exp + tol)
    begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (mapped[a])
      model[a] = v;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rchk(input logic [7:0] a);
    logic [7:0] v;
    rd(a, v);
    chk_byte(v, mapped[a] ? model[a] : 8'h00);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task automatic setf(input logic [2:0] f);
    @(posedge core_clk);
    {fg, stp, alm} <= f;
  endtask

  task automatic wrap_up;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    seed = 32'hbee8fb3c;
    {rst_b, reg_wr, reg_rd, trig_req, bce, fg, stp, alm, pass} = '0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    lag = 8'd3;
    fuse = 8'($random(seed));
    mapped[OFS_PIN_CONFIG] = 1;
    mapped[OFS_SOFT_TRIG] = 1;
    mapped[OFS_LOWPOWER] = 1;
    mapped[OFS_GAIN_ADJ] = 1;
    model[OFS_PIN_CONFIG] = 8'h00;
    model[OFS_SOFT_TRIG] = 8'h01;
    model[OFS_LOWPOWER] = 8'h88;
    model[OFS_GAIN_ADJ] = fuse;
    cyc(4);
    chk_byte(gain, fuse);
    chk_bit(trig, 1'b1);
    @(posedge core_clk);
    rst_b <= 1'b1;
    rchk(OFS_PIN_CONFIG);
    rchk(OFS_SOFT_TRIG);
    rchk(OFS_LOWPOWER);
    rchk(OFS_GAIN_ADJ);
    wr(8'h6d, 8'h5a);
    rchk(8'h6d);
    d = 8'($random(seed));
    wr(OFS_GAIN_ADJ, d);
    rchk(OFS_GAIN_ADJ);
    chk_byte(gain, d);
    $display("test registers done");

    // Software source ignores the pin; pin source ignores the bit
    @(posedge core_clk);
    trig_req <= 1'b0;
    cyc(4);
    chk_bit(trig, 1'b1);
    wr(OFS_SOFT_TRIG, 8'h00);
    chk_bit(trig, 1'b0);
    wr(OFS_PIN_CONFIG, 8'h01);
    for (k = 0; k < 4; k++)
    begin
      @(posedge core_clk);
      lag <= (k < 2) ? 8'd3 : 8'd37;
      trig_req <= ~k[0];
      wr(OFS_SOFT_TRIG, {7'h00, k[0]});
      cyc(6);
      chk_bit(trig, ~k[0]);
    end
    wr(OFS_PIN_CONFIG, 8'h00);
    wr(OFS_SOFT_TRIG, 8'h01);
    $display("test trigger source done");

    // Interrupt raise, mask and clear
    wr(OFS_IRQ_STATUS, 8'hff);
    wr(OFS_IRQ_MASK, 8'h01);
    k = rises;
    setf(3'b100);
    cyc(3);
    chk_bit(irq, 1'b1);
    chk_span(rises, k + 1, 0);
    rd(OFS_IRQ_STATUS, d);
    chk_bit(d[IRQ_FOREGROUND_COMPLETE_FLAG], 1'b1);
    wr(OFS_IRQ_STATUS, 8'h01);
    chk_bit(irq, 1'b0);
    setf(3'b101);
    cyc(3);
    chk_bit(irq, 1'b0);
    rd(OFS_IRQ_STATUS, d);
    chk_bit(d[IRQ_ALARM], 1'b1);
    wr(OFS_IRQ_MASK, 8'h04);
    chk_bit(irq, 1'b1);
    wr(OFS_IRQ_STATUS, 8'hff);
    chk_bit(irq, 1'b0);
    wr(OFS_IRQ_MASK, 8'h00);
    $display("test interrupt done");

    // Status pin routing for every select code
    for (k = 0; k < 4; k++)
    begin
      setf(3'($random(seed)));
      wr(OFS_PIN_CONFIG, {5'h00, k[1:0], 1'b0});
      cyc(2);
      chk_bit(stat_pin, k == 0 ? fg : k == 1 ? stp : k == 2 ? alm : 1'b0);
    end
    wr(OFS_PIN_CONFIG, 8'h00);
    $display("test status pin done");

    // Autonomous sleep, settle and calibration start
    for (k = 4; k < 8; k++)
    begin
      wr(OFS_LOWPOWER, {k[2:0], 2'(1 + k % 3), 3'b001});
      cyc(80);
      chk_bit(slp, 1'b0);
      @(posedge core_clk);
      bce <= 1'b1;
      n = 0;
      while (slp !== 1'b1 && n < 10)
      begin
        cyc(1);
        n++;
      end
      n = 0;
      while (start !== 1'b1 && n < 600)
      begin
        cyc(1);
        n++;
      end
      chk_span(n, int'(SLP[k]) + int'(WAK[1 + k % 3]), 4);
      cyc(1);
      chk_bit(start, 1'b0);
      @(posedge core_clk);
      pass <= 1'b1;
      @(posedge core_clk);
      pass <= 1'b0;
      cyc(3);
      chk_bit(slp, 1'b1);
      wr(OFS_LOWPOWER, 8'h88);
      @(posedge core_clk);
      bce <= 1'b0;
      cyc(2);
      chk_bit(slp, 1'b0);
    end
    $display("test autonomous sleep done");

    // Trigger-controlled sleep ignores the sleep code
    @(posedge core_clk);
    bce <= 1'b1;
    wr(OFS_LOWPOWER, 8'h8b);
    n = 0;
    repeat (200)
    begin
      cyc(1);
      n += (start === 1'b1);
    end
    chk_span(n, 0, 0);
    chk_bit(slp, 1'b1);
    wr(OFS_SOFT_TRIG, 8'h00);
    n = 0;
    while (start !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    chk_span(n, int'(WAK[1]), 6);
    rd(OFS_IRQ_STATUS, d);
    chk_bit(d[IRQ_CAL_START], 1'b1);
    wr(OFS_SOFT_TRIG, 8'h01);
    wr(OFS_LOWPOWER, 8'h88);
    @(posedge core_clk);
    bce <= 1'b0;
    $display("test trigger sleep done");
    wrap_up();
  end
endmodule
